// ==== hsw_consts.vh ====
`ifndef HSW_CONSTS_VH
`define HSW_CONSTS_VH
// ****************************************************
// Register offsets (word index on the plain port)
// ****************************************************
`define HSW_ADDR_WORD      4'h0
`define HSW_ADDR_CTRL      4'h1
`define HSW_ADDR_ALERT_EN  4'h2
`define HSW_ADDR_TURN_THR  4'h3
`define HSW_ADDR_QS_THR    4'h4
`define HSW_ADDR_STATE     4'h5
`define HSW_ADDR_DIAG      4'h6
`define HSW_ADDR_FETCH     4'h7
// ****************************************************
// Health word bit positions
// ****************************************************
`define HSW_BIT_FATAL      0
`define HSW_BIT_HW_FAULT   1
`define HSW_BIT_LINK_FAULT 2
`define HSW_BIT_SW_FAULT   3
`define HSW_BIT_ANY_ALERT  8
`define HSW_BIT_HW_ALERT   9
`define HSW_BIT_GNSS_ALERT 10
`define HSW_BIT_ALGO_ALERT 11
`define HSW_BIT_SENS_ALERT 12
// ****************************************************
// Control register fields
// ****************************************************
`define HSW_CTL_REINIT     0
`define HSW_CTL_DYNAMIC    1
`define HSW_CTL_TURN_IND   2
// ****************************************************
// Reset values
// ****************************************************
`define HSW_CTRL_RST       3'h2
`define HSW_ALERT_EN_RST   4'hE
`define HSW_TURN_THR_RST   16'h00A0
`define HSW_QS_THR_RST     16'h0030
`endif

// ==== hsw_health_word.v ====
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "hsw_consts.vh"
// Behaviour
// - A two-byte health word accompanies every measurement packet.
// - Low byte holds error flags, high byte holds programmable status alerts.
// - Bit 0 is the fatal fault flag, 1 after a fatal error.
// - Bit 1 shows an internal hardware fault.
// - Bit 2 shows a communication fault.
// - Bit 3 shows an internal software fault.
// - Bit 8 is the OR of all asserted and enabled alerts.
// - Each alert type is enabled separately; hardware alert off by default.
// - Bit 10 shows missing satellite-navigation link.
// - Bit 11 shows initialization or high-gain estimation.
// - Bit 12 shows a sensor over-range.
// - Reinit off: over-range raises sensor alert, operation continues.
// - Reinit on: over-range sets fatal flag until quasi-static, then restart.
// - Quasi-static means every filtered rate magnitude below threshold.
// - Reinit-on-rate-limit is off after reset.
// - Dynamic motion off forces high gain; dynamic motion defaults on.
// - Yaw rate above turn threshold reduces accelerometer feedback gain.
// - Turn threshold defaults to 10.0 deg/s about z, adjustable.
// - Optionally the algorithm alert also shows a detected turn.
// - Fetch-packet command returns a diagnostic packet of subsystem status.
module hsw_health_word (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Register port
  input  wire [3:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  // Subsystem fault and status levels (asynchronous)
  input  wire        hw_fault_i,
  input  wire        link_fault_i,
  input  wire        sw_fault_i,
  input  wire        gnss_missing_i,
  input  wire        algo_init_i,
  input  wire        rate_limit_exceeded_i,
  // Filtered rates, signed, 1/16 deg/s per LSB (same clock)
  input  wire [15:0] rate_x_i,
  input  wire [15:0] rate_y_i,
  input  wire [15:0] rate_z_i,
  // Packet emission
  input  wire        packet_emit_i,
  output reg  [15:0] health_status_word_o,
  output reg         packet_word_valid_o,
  // Estimator control
  output reg         high_gain_o,
  output reg         reduced_gain_o,
  output reg         algo_restart_o,
  // Diagnostic packet
  output reg         diag_packet_valid_o,
  output reg  [15:0] diag_packet_o
);

  // ****************************************************
  // Local states
  // ****************************************************
  localparam ST_RUN     = 2'h0;
  localparam ST_HOLD    = 2'h1;
  localparam ST_RESTART = 2'h2;

  // Magnitude of a signed rate
  function [15:0] rate_mag;
    input [15:0] r;
    begin
      // Most negative input maps to 16'h8000, above any threshold below 16'h8000
      rate_mag = r[15] ? (~r + 16'h0001) : r;
    end
  endfunction

  // Register index hit for a write strobe
  function wr_hit;
    input       wr;
    input [3:0] addr;
    input [3:0] idx;
    begin
      wr_hit = wr && (addr == idx);
    end
  endfunction

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  reg  [5:0] sync_a;
  reg  [5:0] sync_b;
  wire [5:0] async_in;
  // Bit order of the synchroniser bank
  assign async_in[0] = hw_fault_i;
  assign async_in[1] = link_fault_i;
  assign async_in[2] = sw_fault_i;
  assign async_in[3] = gnss_missing_i;
  assign async_in[4] = algo_init_i;
  assign async_in[5] = rate_limit_exceeded_i;

  // Two flops per input before any logic; sync_a may go metastable
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (!nrst_i) begin
          sync_a[gi] <= 1'h0;
          sync_b[gi] <= 1'h0;
        end else begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // Only the second flop is read
  wire hw_f   = sync_b[0];
  wire link_f = sync_b[1];
  wire sw_f   = sync_b[2];
  wire gnss_m = sync_b[3];
  wire init_s = sync_b[4];
  wire over_r = sync_b[5];

  // ****************************************************
  // Configuration registers
  // ****************************************************
  // Software-visible settings
  reg  [2:0]  ctrl;
  reg  [3:0]  alert_en;
  reg  [15:0] turn_thr;
  reg  [15:0] qs_thr;
  reg         fetch_req;

  // Control: reinit off, dynamic motion on, turn indication off
  always @(posedge clk_i) begin
    if (!nrst_i)
      ctrl <= `HSW_CTRL_RST;
    else if (wr_hit(reg_wr_i, reg_addr_i, `HSW_ADDR_CTRL))
      ctrl <= reg_wdata_i[2:0];
  end

  // Alert enables; hardware alert starts disabled
  always @(posedge clk_i) begin
    if (!nrst_i)
      alert_en <= `HSW_ALERT_EN_RST;
    else if (wr_hit(reg_wr_i, reg_addr_i, `HSW_ADDR_ALERT_EN))
      alert_en <= reg_wdata_i[3:0];
  end

  // Turn threshold, 1/16 deg/s per LSB
  always @(posedge clk_i) begin
    if (!nrst_i)
      turn_thr <= `HSW_TURN_THR_RST;
    else if (wr_hit(reg_wr_i, reg_addr_i, `HSW_ADDR_TURN_THR))
      turn_thr <= reg_wdata_i;
  end

  // Quasi-static threshold, same scale
  always @(posedge clk_i) begin
    if (!nrst_i)
      qs_thr <= `HSW_QS_THR_RST;
    else if (wr_hit(reg_wr_i, reg_addr_i, `HSW_ADDR_QS_THR))
      qs_thr <= reg_wdata_i;
  end

  // Fetch command: any write to its index, one-cycle request
  always @(posedge clk_i) begin
    if (!nrst_i)
      fetch_req <= 1'h0;
    else
      fetch_req <= wr_hit(reg_wr_i, reg_addr_i, `HSW_ADDR_FETCH);
  end

  // Control fields
  wire reinit_on_rate_limit = ctrl[`HSW_CTL_REINIT];
  wire dynamic_motion       = ctrl[`HSW_CTL_DYNAMIC];
  wire turn_indicate        = ctrl[`HSW_CTL_TURN_IND];

  // ****************************************************
  // Motion detection
  // ****************************************************
  // Per-axis magnitudes of the filtered rates
  wire [15:0] mag_x = rate_mag(rate_x_i);
  wire [15:0] mag_y = rate_mag(rate_y_i);
  wire [15:0] mag_z = rate_mag(rate_z_i);

  // Each axis strictly below the quasi-static threshold
  wire still_x = (mag_x < qs_thr);
  wire still_y = (mag_y < qs_thr);
  wire still_z = (mag_z < qs_thr);

  // Restart allowed only when every axis is still
  wire quasi_static = still_x && still_y && still_z;

  // Yaw is the z axis; strictly above the threshold
  wire turn_det     = (mag_z > turn_thr);

  // ****************************************************
  // Over-range restart sequencer
  // ****************************************************
  // Hold entry and exit conditions
  wire hold_enter = over_r && reinit_on_rate_limit;
  wire hold_leave = !over_r && quasi_static;

  // Restart sequencer state
  reg [1:0] rst_state;
  reg [1:0] next_rst_state;

  // Next state
  always @* begin
    next_rst_state = rst_state;
    case (rst_state)
      ST_RUN: begin
        // Without reinit an over-range only raises the sensor alert
        if (hold_enter)
          next_rst_state = ST_HOLD;
      end
      ST_HOLD: begin
        // Fatal flag stays up through the whole hold
        if (hold_leave)
          next_rst_state = ST_RESTART;
      end
      ST_RESTART: begin
        // Normal start is attempted as the hold ends
        next_rst_state = ST_RUN;
      end
      default:    next_rst_state = ST_RUN;
    endcase
  end

  // State register
  always @(posedge clk_i) begin
    if (!nrst_i)
      rst_state <= ST_RUN;
    else
      rst_state <= next_rst_state;
  end

  // Fatal while holding or restarting
  wire fatal_fault_flag = (rst_state != ST_RUN);

  // ****************************************************
  // Health word assembly
  // ****************************************************
  wire       hw_alert           = hw_f;
  wire       gnss_link_alert    = gnss_m;
  wire       algo_alert         = init_s || high_gain_o ||
                                  (turn_indicate && turn_det);
  wire       sensor_limit_alert = over_r;
  // Each alert gated by its own enable
  wire       hw_alert_on     = hw_alert && alert_en[0];
  wire       gnss_alert_on   = gnss_link_alert && alert_en[1];
  wire       algo_alert_on   = algo_alert && alert_en[2];
  wire       sensor_alert_on = sensor_limit_alert && alert_en[3];
  wire [3:0] alerts = {sensor_alert_on, algo_alert_on,
                       gnss_alert_on, hw_alert_on};
  wire       any_alert_flag = |alerts;
  reg  [15:0] next_word;

  // Bit by bit; spare positions held low for a stable word
  always @* begin
    next_word = 16'h0000;
    // Error byte
    next_word[`HSW_BIT_FATAL]      = fatal_fault_flag;
    next_word[`HSW_BIT_HW_FAULT]   = hw_f;
    next_word[`HSW_BIT_LINK_FAULT] = link_f;
    next_word[`HSW_BIT_SW_FAULT]   = sw_f;
    // Status byte, masked by the enables
    next_word[`HSW_BIT_ANY_ALERT]  = any_alert_flag;
    next_word[`HSW_BIT_HW_ALERT]   = alerts[0];
    next_word[`HSW_BIT_GNSS_ALERT] = alerts[1];
    next_word[`HSW_BIT_ALGO_ALERT] = alerts[2];
    next_word[`HSW_BIT_SENS_ALERT] = alerts[3];
  end

  // Word refreshed every cycle so each packet carries current flags
  always @(posedge clk_i) begin
    if (!nrst_i)
      health_status_word_o <= 16'h0000;
    else
      health_status_word_o <= next_word;
  end

  // Packet strobe delayed to line up with the word
  always @(posedge clk_i) begin
    if (!nrst_i)
      packet_word_valid_o <= 1'h0;
    else
      packet_word_valid_o <= packet_emit_i;
  end

  // ****************************************************
  // Estimator gain control
  // ****************************************************
  // High gain while dynamic motion is off
  always @(posedge clk_i) begin
    if (!nrst_i)
      high_gain_o <= 1'h0;
    else
      high_gain_o <= !dynamic_motion;
  end

  // Turn coasting; high gain takes precedence over it
  always @(posedge clk_i) begin
    if (!nrst_i)
      reduced_gain_o <= 1'h0;
    else
      reduced_gain_o <= turn_det && dynamic_motion;
  end

  // One-cycle restart request as the hold is left
  always @(posedge clk_i) begin
    if (!nrst_i)
      algo_restart_o <= 1'h0;
    else
      algo_restart_o <= (rst_state == ST_RESTART);
  end

  // ****************************************************
  // Diagnostic packet
  // ****************************************************
  reg [15:0] next_diag;

  // Snapshot of every subsystem's status
  always @* begin
    next_diag      = 16'h0000;
    next_diag[0]   = fatal_fault_flag;
    next_diag[1]   = hw_f;
    next_diag[2]   = link_f;
    next_diag[3]   = sw_f;
    next_diag[4]   = hw_f;
    next_diag[5]   = gnss_m;
    next_diag[6]   = init_s;
    next_diag[7]   = over_r;
    next_diag[9:8] = rst_state;
    next_diag[10]  = quasi_static;
    next_diag[11]  = turn_det;
  end

  // One-cycle valid; data stands until the next fetch
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      diag_packet_valid_o <= 1'h0;
      diag_packet_o       <= 16'h0000;
    end else begin
      diag_packet_valid_o <= fetch_req;
      if (fetch_req)
        diag_packet_o <= next_diag;
    end
  end

  // ****************************************************
  // Register read port
  // ****************************************************
  reg [15:0] next_rdata;

  // Read multiplexer; unmapped indices read zero
  always @* begin
    case (reg_addr_i)
      `HSW_ADDR_WORD:     next_rdata = health_status_word_o;
      `HSW_ADDR_CTRL:     next_rdata = {13'h0000, ctrl};
      `HSW_ADDR_ALERT_EN: next_rdata = {12'h000, alert_en};
      `HSW_ADDR_TURN_THR: next_rdata = turn_thr;
      `HSW_ADDR_QS_THR:   next_rdata = qs_thr;
      `HSW_ADDR_STATE:    next_rdata = {11'h000, turn_det, quasi_static,
                                        1'h0, rst_state};
      `HSW_ADDR_DIAG:     next_rdata = diag_packet_o;
      default:            next_rdata = 16'h0000;
    endcase
  end

  // Data stands one cycle after the strobe, zero otherwise
  always @(posedge clk_i) begin
    if (!nrst_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
    else
      reg_rdata_o <= 16'h0000;
  end

endmodule

// ==== hsw_host.sv ====
`timescale 1ns/10ps
// ***
// Host packet reader
// ***
module hsw_host (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Packet side
  input  wire        valid_i,
  input  wire [15:0] word_i,
  output reg         emit_o,
  output reg  [15:0] last_o
);
  reg [2:0] cnt;
  // Packet every eighth cycle, last word kept
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt    <= 3'h0;
      emit_o <= 1'b0;
      last_o <= 16'h0000;
    end else begin
      cnt    <= cnt + 3'h1;
      emit_o <= (cnt == 3'h7);
      if (valid_i)
        last_o <= word_i;
    end
  end
endmodule

// ==== hsw_monitor.sv ====
`timescale 1ns/10ps
// ***
// Health word checker
// ***
module hsw_monitor (
  // Clock and reset
  input wire        clk_i,
  input wire        nrst_i,
  // Register port
  input wire [3:0]  reg_addr_i,
  input wire        reg_wr_i,
  // Fault inputs
  input wire        hw_fault_i,
  input wire        link_fault_i,
  input wire        sw_fault_i,
  input wire        rate_limit_exceeded_i,
  // Packet and control outputs
  input wire        packet_emit_i,
  input wire [15:0] health_status_word_o,
  input wire        packet_word_valid_o,
  input wire        high_gain_o,
  input wire        reduced_gain_o,
  input wire        algo_restart_o,
  input wire        diag_packet_valid_o
);
  wire [15:0] w = health_status_word_o;
  reg  [1:0]  up;
  // Cycles since reset release, saturating
  always @(posedge clk_i)
    if (!nrst_i)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_spare_zero: assert property (w[7:4] == 4'h0 && w[15:13] == 3'h0)
    else $error("spare bits set");
  a_summary_alert: assert property (w[8] == |w[12:9])
    else $error("summary alert wrong");
  a_fault_flags: assert property (up == 2'h3 |-> w[3:1] ==
    {$past(sw_fault_i, 3), $past(link_fault_i, 3), $past(hw_fault_i, 3)})
    else $error("fault flags wrong");
  a_fatal_cause: assert property ($rose(w[0]) |->
    $past(rate_limit_exceeded_i, 3) || $past(rate_limit_exceeded_i, 4))
    else $error("fatal flag without over-range");
  a_packet_word: assert property (packet_emit_i |=> packet_word_valid_o)
    else $error("packet word missing");
  a_restart_pulse: assert property (algo_restart_o |->
    $past(w[0]) ##1 !algo_restart_o) else $error("restart pulse wrong");
  a_gain_excl: assert property (reduced_gain_o |-> !high_gain_o)
    else $error("reduced and high gain together");
  a_fetch_reply: assert property (diag_packet_valid_o |->
    $past(reg_wr_i && reg_addr_i == 4'h7, 2)) else $error("stray diag packet");
  c_restart: cover property (algo_restart_o);
  c_fetch: cover property (diag_packet_valid_o);
  c_turn: cover property (reduced_gain_o);
endmodule
bind hsw_health_word hsw_monitor i_hsw_monitor (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .hw_fault_i(hw_fault_i), .sw_fault_i(sw_fault_i),
  .link_fault_i(link_fault_i), .packet_emit_i(packet_emit_i),
  .rate_limit_exceeded_i(rate_limit_exceeded_i),
  .health_status_word_o(health_status_word_o),
  .packet_word_valid_o(packet_word_valid_o), .high_gain_o(high_gain_o),
  .reduced_gain_o(reduced_gain_o), .algo_restart_o(algo_restart_o),
  .diag_packet_valid_o(diag_packet_valid_o));

// ==== testbench.sv ====
`timescale 1ns/10ps
// ***
// Health word testbench
// ***
module testbench;
  reg         clk_i, nrst_i, wr_s, rd_s;
  reg  [3:0]  adr;
  reg  [5:0]  flt;
  reg  [15:0] wd, rx, ry, rz;
  reg  [31:0] v;
  wire [15:0] rdat, word, last;
  wire        emit, pv, hg, rg, rs, dv;
  integer     failures, n_tests, k, seed;
  hsw_health_word i_hsw_health_word (.clk_i(clk_i), .nrst_i(nrst_i),
    .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdat), .hw_fault_i(flt[0]), .link_fault_i(flt[1]),
    .sw_fault_i(flt[2]), .gnss_missing_i(flt[3]), .algo_init_i(flt[4]),
    .rate_limit_exceeded_i(flt[5]), .rate_x_i(rx), .rate_y_i(ry),
    .rate_z_i(rz), .packet_emit_i(emit), .health_status_word_o(word),
    .packet_word_valid_o(pv), .high_gain_o(hg), .reduced_gain_o(rg),
    .algo_restart_o(rs), .diag_packet_valid_o(dv), .diag_packet_o());
  hsw_host i_hsw_host (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(pv),
    .word_i(word), .emit_o(emit), .last_o(last));
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  // Expected word from flags, enables and gain state
  function [15:0] expw(input [5:0] f, input [3:0] en, input g);
    reg [3:0] a;
    begin
      a = {f[5], f[4] | g, f[3], f[0]} & en;
      expw = {3'h0, a, |a, 4'h0, f[2:0], 1'b0};
    end
  endfunction
  task cmp(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Compare a settled output at the falling edge, back on a rising edge
  task look(input [63:0] nm, input [15:0] e, input [1:0] s);
    begin
      @(negedge clk_i);
      case (s)
        2'h0:    cmp(nm, e, last);
        2'h1:    cmp(nm, e, {15'h0000, hg});
        2'h2:    cmp(nm, e, {15'h0000, rg});
        default: cmp(nm, e, {15'h0000, rs});
      endcase
      @(posedge clk_i);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      adr  <= a;
      wd   <= d;
      wr_s <= 1'b1;
      @(posedge clk_i);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e, input [63:0] nm);
    begin
      @(posedge clk_i);
      adr  <= a;
      rd_s <= 1'b1;
      @(posedge clk_i);
      rd_s <= 1'b0;
      @(negedge clk_i);
      cmp(nm, e, rdat);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    seed = 32'h53f4;
    failures = 0;
    n_tests = 0;
    {clk_i, nrst_i, wr_s, rd_s, adr, flt} = 14'h0000;
    {wd, rx, ry, rz} = 64'h0;
    cyc(4);
    nrst_i <= 1'b1;
    rd(4'h1, 16'h0002, "ctrl");
    rd(4'h2, 16'h000E, "alert_en");
    rd(4'h3, 16'h00A0, "turn_thr");
    rd(4'hF, 16'h0000, "unmapped");
    for (k = 0; k < 16; k = k + 1) begin
      v = $random(seed);
      wr(4'h2, {12'h000, v[9:6]});
      flt <= v[5:0];
      cyc(14);
      look("word", expw(v[5:0], v[9:6], 1'b0), 2'h0);
    end
    wr(4'h2, 16'h000F);
    flt <= 6'h00;
    wr(4'h1, 16'h0000);
    cyc(14);
    look("highgain", 16'h0001, 2'h1);
    look("word", expw(6'h00, 4'hF, 1'b1), 2'h0);
    wr(4'h1, 16'h0006);
    wr(4'h3, 16'h0040);
    rz <= 16'h0041;
    cyc(14);
    look("reduced", 16'h0001, 2'h2);
    look("word", expw(6'h00, 4'hF, 1'b1), 2'h0);
    rz <= 16'h0040;
    cyc(14);
    look("reduced", 16'h0000, 2'h2);
    wr(4'h1, 16'h0003);
    rz <= 16'h0000;
    rx <= 16'h0100;
    flt <= 6'h20;
    cyc(14);
    look("word", expw(6'h20, 4'hF, 1'b0) | 16'h0001, 2'h0);
    flt <= 6'h00;
    rx <= 16'h0000;
    ry <= 16'hFFD0;
    cyc(14);
    look("word", 16'h0001, 2'h0);
    ry <= 16'hFFD1;
    for (k = 0; k < 20 && rs !== 1'b1; k = k + 1)
      @(negedge clk_i);
    cmp("restart", 16'h0001, {15'h0000, rs});
    cyc(14);
    look("word", 16'h0000, 2'h0);
    wr(4'h7, 16'h0000);
    for (k = 0; k < 4 && dv !== 1'b1; k = k + 1)
      @(negedge clk_i);
    cmp("diag_vld", 16'h0001, {15'h0000, dv});
    rd(4'h6, 16'h0400, "diag");
    rd(4'h5, 16'h0008, "state");
    rd(4'h0, 16'h0000, "word");
    finish_test;
  end
  // Watchdog against a hang
  initial begin
    #100000;
    failures = failures + 1;
    finish_test;
  end
endmodule
